// ---- bench/adc_result_format_and_input_select_tb.sv ----
// Self-checking bench of the converter selection block
`timescale 1ns/1ps
module adc_result_format_and_input_select_tb;
  import adc_sel_pkg::*;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0, en = 1'b1;
  logic cs, ce, busy, diff, irq;
  logic [3:0] addr_i = 4'h0, dly = 4'h1;
  logic [4:0] chan;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic signed [10:0] val = 11'h000, raw;
  logic signed [10:0] corner [8] = '{11'h3FF, 11'h7FF, 11'h600, 11'h5FF, 11'h1FF, 11'h200,
    11'h400, 11'h000};
  ref_source_t rsrc;
  int n_mismatch = 0, checked = 0, seed = 32'hD893;
  always #10 mclk_i = ~mclk_i;
  adc_result_format_and_input_select i_dut (.mclk_i, .rst_n_i, .clk_en_i(en), .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .conv_start_i(cs), .conv_end_i(ce), .raw_i(raw),
    .conv_busy_o(busy), .ref_source_o(rsrc), .channel_gain_select_o(chan),
    .differential_o(diff), .irq_o(irq));
  analog_front_model i_afe (.mclk_i, .go_i(go), .delay_i(dly), .value_i(val),
    .conv_start_o(cs), .conv_end_o(ce), .raw_o(raw));
  // ====
  // Helpers
  function automatic logic [15:0] exp_res(logic signed [10:0] v, logic [4:0] c, logic la);
    logic [9:0] r;
    if (c inside {[5'h08:5'h1D]})
      r = v > 11'sh1FF ? 10'h1FF : v < 11'sh600 ? 10'h200 : v[9:0];
    else
      r = v[10] ? 10'h000 : v[9:0];
    return la ? {r, 6'h00} : {6'h00, r};
  endfunction : exp_res
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic wr(logic [3:0] a, logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    d = rdata_o;
  endtask : rd
  task automatic chk_res(logic [15:0] e);
    logic [7:0] lo, hi;
    rd(4'h1, lo);
    rd(4'h2, hi);
    chk({hi, lo}, e);
  endtask : chk_res
  task automatic start(logic signed [10:0] v, logic [3:0] d);
    val <= v;
    dly <= d;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask : start
  task automatic wait_idle;
    int i;
    for (i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge mclk_i);
    if (i == 40)
      n_mismatch++;
    if (i == 40)
      end_sim();
  endtask : wait_idle
  // ====
  // Main sequence
  initial
  begin
    logic [7:0] d, s;
    logic signed [10:0] v;
    int k;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(4'h0, d);
    chk(d, 8'h00);
    chk(rsrc, 4'h1);
    rd(4'hF, d);
    chk(d, 8'h00);
    $display("reset test done");
    for (k = 0; k < 24; k++)
    begin
      s = 8'($random(seed));
      v = 11'($random(seed));
      s[7:6] = k[1:0];
      if (k < 16)
        s[4:0] = k[0] ? 5'h10 : 5'h03;
      if (k < 16)
        v = corner[k[3:1]];
      wr(4'h0, s);
      rd(4'h0, d);
      chk(d, s);
      chk(rsrc, 4'h1 << s[7:6]);
      start(v, 4'(k % 9 + 1));
      wait_idle();
      rd(4'h3, d);
      chk(d, 8'h01);
      chk_res(exp_res(v, s[4:0], s[5]));
      wr(4'h0, s ^ 8'h20);
      chk_res(exp_res(v, s[4:0], !s[5]));
      wr(4'h3, 8'h01);
    end
    $display("conversion test done");
    wr(4'h0, 8'h00);
    start(11'h670, 4'hC);
    wr(4'h0, 8'hED);
    chk(rsrc, 4'h1);
    chk(chan, 5'h00);
    chk_res(exp_res(v, s[4:0], 1'b1));
    wait_idle();
    @(posedge mclk_i);
    chk(rsrc, 4'h8);
    chk(chan, 5'h0D);
    chk(diff, 1'b1);
    chk_res(16'h0000);
    start(11'h670, 4'h2);
    wait_idle();
    chk_res(16'h9C00);
    wr(4'h0, 8'hCD);
    chk_res(16'h0270);
    $display("deferral test done");
    wr(4'h4, 8'h01);
    chk(irq, 1'b1);
    wr(4'h4, 8'h00);
    chk(irq, 1'b0);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h01);
    chk(irq, 1'b0);
    $display("interrupt test done");
    en <= 1'b0;
    wr(4'h0, 8'h55);
    en <= 1'b1;
    rd(4'h0, d);
    chk(d, 8'hCD);
    $display("clock enable test done");
    end_sim();
  end
endmodule : adc_result_format_and_input_select_tb
bind adc_result_format_and_input_select adc_sel_checker i_chk (.mclk_i, .rst_n_i, .clk_en_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .conv_start_i, .conv_end_i, .conv_busy_o,
  .ref_source_o, .channel_gain_select_o, .differential_o, .irq_o);

// ---- bench/adc_sel_checker.sv ----
// Port assertions of the converter selection block
`timescale 1ns/1ps
module adc_sel_checker (
  input wire logic                      mclk_i,
  input wire logic                      rst_n_i,
  input wire logic                      clk_en_i,
  input wire logic [3:0]                addr_i,
  input wire logic [7:0]                wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      conv_start_i,
  input wire logic                      conv_end_i,
  input wire logic                      conv_busy_o,
  input wire adc_sel_pkg::ref_source_t  ref_source_o,
  input wire logic [4:0]                channel_gain_select_o,
  input wire logic                      differential_o,
  input wire logic                      irq_o
);
  import adc_sel_pkg::*;
  logic idle_wr, hold, done;
  assign idle_wr = clk_en_i && wr_i && addr_i == 4'h0 && !conv_busy_o && !conv_start_i;
  assign hold = conv_busy_o && !conv_end_i;
  assign done = clk_en_i && conv_busy_o && conv_end_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ====
  // Assertions
  AST_REF_HOLD: assert property (hold |=> $stable(ref_source_o))
    else $error("reference moved while busy");
  AST_CHAN_HOLD: assert property (hold |=> $stable(channel_gain_select_o))
    else $error("channel moved while busy");
  AST_REF_SET: assert property (idle_wr |=> ref_source_o == 4'h1 << $past(wdata_i[7:6]))
    else $error("reference decode wrong");
  AST_CHAN_SET: assert property (idle_wr |=> channel_gain_select_o == $past(wdata_i[4:0]))
    else $error("channel not applied");
  AST_DIFF: assert property (!conv_busy_o && !$past(wr_i) |->
    differential_o == (channel_gain_select_o inside {[5'h08:5'h1D]}))
    else $error("differential flag wrong");
  AST_RD_QUIET: assert property (rdata_o != 8'h00 |-> $past(rd_i && clk_en_i))
    else $error("read data outside read slot");
  AST_END: assert property (done |=> !conv_busy_o)
    else $error("busy after conversion end");
  AST_IRQ: assert property ($rose(irq_o) |-> $past(done) || $past(wr_i && addr_i == 4'h4))
    else $error("interrupt without cause");
  cover property (done);
  cover property (idle_wr);
  cover property ($rose(irq_o));
endmodule : adc_sel_checker

// ---- bench/analog_front_model.sv ----
// Analog front end model: start and end pulses with a raw value
`timescale 1ns/1ps
module analog_front_model (
  input wire logic               mclk_i,
  input wire logic               go_i,
  input wire logic [3:0]         delay_i,
  input wire logic signed [10:0] value_i,
  output logic                   conv_start_o = 1'b0,
  output logic                   conv_end_o = 1'b0,
  output logic signed [10:0]     raw_o = 11'h000
);
  logic [4:0] cnt = 5'h00;
  always @(posedge mclk_i)
  begin
    conv_start_o <= go_i;
    conv_end_o <= cnt == 5'h01;
    raw_o <= cnt == 5'h01 ? value_i : ~raw_o;
    if (go_i)
      cnt <= {1'b0, delay_i} + 5'h01;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
endmodule : analog_front_model

// ---- inc/adc_sel_pkg.sv ----
// Types of the converter input selection and result block
package adc_sel_pkg;

  // ========================================================================
  // Reference source decode
  typedef enum logic [3:0] {
    REF_OFF_EXT  = 4'b0001,
    REF_AVSUPPLY = 4'b0010,
    REF_NONE     = 4'b0100,
    REF_INT_BG   = 4'b1000
  } ref_source_t;

  // ========================================================================
  // Conversion phase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } conv_state_t;

endpackage : adc_sel_pkg

// ---- inc/adc_sel_regs.svh ----
// Register offsets, field positions, reset values and codes of the input selection block
`ifndef ADC_SEL_REGS_SVH
`define ADC_SEL_REGS_SVH

// ==========================================================================
// Register offsets
`define OFS_INPUT_SELECT   4'h0
`define OFS_RESULT_LOW     4'h1
`define OFS_RESULT_HIGH    4'h2
`define OFS_IRQ_STATUS     4'h3
`define OFS_IRQ_MASK       4'h4
`define OFS_CONV_STATUS    4'h5

// ==========================================================================
// Field positions of the input selection register
`define REF_SEL_HI         7
`define REF_SEL_LO         6
`define LEFT_ADJ_BIT       5
`define CHAN_HI            4
`define CHAN_LO            0

// ==========================================================================
// Reset values and codes
`define INPUT_SELECT_RST   8'h00
`define CHAN_RST           5'h00
`define RESULT_RST         10'h000
`define BYTE_ZERO          8'h00
`define READ_ZERO          8'h00
`define REF_EXT_PIN        2'h0
`define REF_SUPPLY         2'h1
`define REF_RESERVED       2'h2
`define REF_INTERNAL       2'h3
`define CHAN_SE_LAST       5'h07
`define CHAN_DIFF_FIRST    5'h08
`define CHAN_DIFF_LAST     5'h1D
`define CHAN_SE_BANDGAP    5'h1E
`define CHAN_SE_GROUND     5'h1F
`define UNSIGNED_MAX       10'h3FF
`define SIGNED_MAX         10'h1FF
`define SIGNED_MIN         10'h200

`endif

// ---- rtl/adc_result_format_and_input_select.sv ----
// Converter input selection register, result coding and result registers
//
// Overview of operation
// - Single-ended results are unsigned; 0x000 ground, 0x3FF reference less one step.
// - Differential results are two's complement from -512 up to +511.
// - In differential mode the top result bit is the sign; one means negative.
// - Finished result is held in two result bytes once the done flag rises.
// - Selection register is 8 bits RW, reset zero: ref 7:6, left 5, chan 4:0.
// - Reference change during a conversion applies only after it completes.
// - Reference code 00 pin, 01 supply, 10 reserved, 11 internal 2.56V.
// - Left-adjust one gives left-aligned result, zero gives right-aligned.
// - Left-adjust change realigns the result bytes at once, even mid-conversion.
// - Channel/gain code picks inputs; changes mid-conversion apply after completion.
// - Done flag is set when conversion ends and result bytes are updated.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "adc_sel_regs.svh"

module adc_result_format_and_input_select #(
  parameter int RES_W = 10,
  parameter int ADDR_W = 4
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [7:0]             rdata_o,
  input  wire logic              conv_start_i,
  input  wire logic              conv_end_i,
  input  wire logic signed [RES_W:0] raw_i,
  output logic                   conv_busy_o,
  output adc_sel_pkg::ref_source_t ref_source_o,
  output logic [4:0]             channel_gain_select_o,
  output logic                   differential_o,
  output logic                   irq_o
);
  import adc_sel_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0]       input_select_reg;
    logic [1:0]       ref_active;
    logic [4:0]       chan_active;
    logic [RES_W-1:0] result;
    logic             conversion_done_flag;
    logic             irq_mask;
    conv_state_t      state;
    logic [7:0]       rdata;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [RES_W-1:0] coded;
  logic [7:0]       result_low_byte;
  logic [7:0]       result_high_byte;
  logic             diff_active;
  logic             wr_sel;

  // ========================================================================
  // Differential decode of the applied channel code
  always_comb
  begin
    diff_active = (cur.chan_active >= `CHAN_DIFF_FIRST) &&
                  (cur.chan_active <= `CHAN_DIFF_LAST);
  end

  result_coder #(
    .RES_W (RES_W)
  ) u_coder (
    .differential_i (diff_active),
    .raw_i          (raw_i),
    .code_o         (coded)
  );

  result_aligner #(
    .RES_W (RES_W)
  ) u_align (
    .result_i      (cur.result),
    .left_adjust_i (cur.input_select_reg[`LEFT_ADJ_BIT]),
    .low_o         (result_low_byte),
    .high_o        (result_high_byte)
  );

  // ========================================================================
  // Next state
  always_comb
  begin
    next_cur = cur;
    wr_sel   = wr_i && (addr_i == `OFS_INPUT_SELECT);
    if (wr_sel)
      next_cur.input_select_reg = wdata_i;
    else if (wr_i && (addr_i == `OFS_IRQ_MASK))
      next_cur.irq_mask = wdata_i[0];

    case (cur.state)
      ST_IDLE:
      begin
        next_cur.ref_active  = wr_sel ? wdata_i[`REF_SEL_HI:`REF_SEL_LO]
                                      : cur.input_select_reg[`REF_SEL_HI:`REF_SEL_LO];
        next_cur.chan_active = wr_sel ? wdata_i[`CHAN_HI:`CHAN_LO]
                                      : cur.input_select_reg[`CHAN_HI:`CHAN_LO];
        if (conv_start_i)
          next_cur.state = ST_BUSY;
      end
      ST_BUSY:
      begin
        if (conv_end_i)
        begin
          next_cur.result = coded;
          next_cur.state  = ST_IDLE;
        end
      end
      default:
        next_cur.state = ST_IDLE;
    endcase

    if (wr_i && (addr_i == `OFS_IRQ_STATUS) && wdata_i[0])
      next_cur.conversion_done_flag = 1'b0;
    if ((cur.state == ST_BUSY) && conv_end_i)
      next_cur.conversion_done_flag = 1'b1;

    // Register read, valid one cycle later
    next_cur.rdata = `READ_ZERO;
    if (rd_i)
    begin
      if (addr_i == `OFS_INPUT_SELECT)
        next_cur.rdata = cur.input_select_reg;
      else if (addr_i == `OFS_RESULT_LOW)
        next_cur.rdata = result_low_byte;
      else if (addr_i == `OFS_RESULT_HIGH)
        next_cur.rdata = result_high_byte;
      else if (addr_i == `OFS_IRQ_STATUS)
        next_cur.rdata = {7'h00, cur.conversion_done_flag};
      else if (addr_i == `OFS_IRQ_MASK)
        next_cur.rdata = {7'h00, cur.irq_mask};
      else if (addr_i == `OFS_CONV_STATUS)
        next_cur.rdata = {7'h00, cur.state == ST_BUSY};
      else
        next_cur.rdata = `READ_ZERO;
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      cur.input_select_reg     <= `INPUT_SELECT_RST;
      cur.ref_active           <= `REF_EXT_PIN;
      cur.chan_active          <= `CHAN_RST;
      cur.result               <= `RESULT_RST;
      cur.conversion_done_flag <= 1'b0;
      cur.irq_mask             <= 1'b0;
      cur.state                <= ST_IDLE;
      cur.rdata                <= `READ_ZERO;
    end
    else if (clk_en_i)
      cur <= next_cur;
  end

  // ========================================================================
  // Outputs
  always_comb
  begin
    case (cur.ref_active)
      `REF_EXT_PIN:  ref_source_o = REF_OFF_EXT;
      `REF_SUPPLY:   ref_source_o = REF_AVSUPPLY;
      `REF_INTERNAL: ref_source_o = REF_INT_BG;
      default:       ref_source_o = REF_NONE;
    endcase
  end

  assign rdata_o               = cur.rdata;
  assign conv_busy_o           = (cur.state == ST_BUSY);
  assign channel_gain_select_o = cur.chan_active;
  assign differential_o        = diff_active;
  assign irq_o                 = cur.conversion_done_flag & cur.irq_mask;

endmodule : adc_result_format_and_input_select

// ---- rtl/result_aligner.sv ----
// Result alignment into high and low bytes
`timescale 1ns/1ps
`include "adc_sel_regs.svh"

module result_aligner #(
  parameter int RES_W = 10
) (
  input  wire logic [RES_W-1:0] result_i,
  input  wire logic             left_adjust_i,
  output logic [7:0]            low_o,
  output logic [7:0]            high_o
);
  import adc_sel_pkg::*;

  // ========================================================================
  // Byte placement
  always_comb
  begin
    if (left_adjust_i)
    begin
      // bits 9:2 high, 1:0 top of low
      high_o = result_i[RES_W-1:RES_W-8];
      low_o  = {result_i[RES_W-9:0], {(16-RES_W){1'b0}}};
    end
    else
    begin
      high_o = {{(16-RES_W){1'b0}}, result_i[RES_W-1:8]};
      low_o  = result_i[7:0];
    end
  end

endmodule : result_aligner

// ---- rtl/result_coder.sv ----
// Result coding: clamp raw value as unsigned or two's complement
`timescale 1ns/1ps
`include "adc_sel_regs.svh"

module result_coder #(
  parameter int RES_W = 10
) (
  input  wire logic             differential_i,
  input  wire logic signed [RES_W:0] raw_i,
  output logic [RES_W-1:0]      code_o
);
  import adc_sel_pkg::*;

  // ========================================================================
  // Clamp to coding range
  always_comb
  begin
    if (differential_i)
    begin
      if (raw_i > $signed({1'b0, `SIGNED_MAX}))
        code_o = `SIGNED_MAX;
      else if (raw_i < -$signed({1'b0, `SIGNED_MIN}))
        code_o = `SIGNED_MIN;
      else
        code_o = raw_i[RES_W-1:0];
    end
    else
    begin
      if (raw_i[RES_W])
        code_o = `RESULT_RST;
      else
        code_o = raw_i[RES_W-1:0];
    end
  end

endmodule : result_coder
